// [design/sdil_pkg.sv]
// shared constants, command codes and carrier types of the serial dac input logic
package sdil_pkg;

	// word layout: control field on top, data field below
	localparam int WORD_BITS = 16;
	localparam int CTRL_BITS = 4;
	localparam int DATA_BITS = 12;
	localparam int CTRL_MSB = 15;
	localparam int DATA_MSB = 11;
	localparam int COUNT_BITS = 5;
	localparam logic [COUNT_BITS-1:0] COUNT_FULL = 5'h10;
	localparam logic [COUNT_BITS-1:0] COUNT_MAX = 5'h1F;
	localparam logic [COUNT_BITS-1:0] COUNT_FIRST = 5'h01;

	// reset values of the latches and of the idle chip select level
	localparam logic [DATA_BITS-1:0] LATCH_RESET = 12'h000;
	localparam logic [CTRL_BITS-1:0] CMD_RESET = 4'h0;
	localparam logic CSN_IDLE = 1'b1;

	// control command codes, anything else is a no-op
	localparam logic [CTRL_BITS-1:0] CMD_LOAD = 4'h0;
	localparam logic [CTRL_BITS-1:0] CMD_UPDATE = 4'h1;
	localparam logic [CTRL_BITS-1:0] CMD_LOAD_UPDATE = 4'h2;

	// received word as carried from the link domain
	typedef struct packed {
		logic [CTRL_BITS-1:0] controlCommandField;
		logic [DATA_BITS-1:0] dataField;
	} sdil_word_t;

	// word plus the number of clock edges seen in its frame
	typedef struct packed {
		sdil_word_t word;
		logic [COUNT_BITS-1:0] bitCount;
	} sdil_frame_t;

	// one-cycle event pulses of the decoder
	typedef struct packed {
		logic loadPulse;
		logic updatePulse;
		logic noopPulse;
		logic shortPulse;
	} sdil_event_t;

	// decoder phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_FRAME,
		PH_DECODE
	} sdil_phase_t;

endpackage : sdil_pkg

// [design/sdil_sync.sv]
// three-stage synchroniser for a pin level, changes once stages two and three agree
module sdil_sync #(
	parameter logic RESET_LEVEL = 1'b1 // level shown during reset
) (
	input wire logic clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic pinIn, // asynchronous pin level
	output logic levelOut // filtered level in clk domain
);
	import sdil_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sdil_sync_t;

	sdil_sync_t st_r;
	sdil_sync_t st_nxt;

	// shift the pin through, accept a change only when the last two agree
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pinIn;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3)
		begin
			st_nxt.level = st_r.s3;
		end
	end

	// register the state
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign levelOut = st_r.level;

endmodule : sdil_sync

// [design/sdil_shift.sv]
// link-side shift register clocked by the serial clock
module sdil_shift (
	input wire logic serialClk, // serial clock from the host
	input wire logic chipSelN, // chip select, active low
	input wire logic serialData, // serial data from the host
	output sdil_pkg::sdil_frame_t frameOut // shifted word and edge count
);
	import sdil_pkg::*;

	sdil_frame_t st_r;
	sdil_frame_t st_nxt;
	logic frameSeen_r;

	// marks that the current frame has had an edge; cleared while deselected
	always_ff @(posedge serialClk or posedge chipSelN)
	begin
		if (chipSelN)
		begin
			frameSeen_r <= 1'b0;
		end
		else
		begin
			frameSeen_r <= 1'b1;
		end
	end

	// msb first shift, count restarts on the first edge of a frame
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.word = {st_r.word[WORD_BITS-2:0], serialData};
		if (!frameSeen_r)
		begin
			st_nxt.bitCount = COUNT_FIRST;
		end
		else if (st_r.bitCount != COUNT_MAX)
		begin
			st_nxt.bitCount = st_r.bitCount + COUNT_FIRST;
		end
	end

	// shift only while selected; the chip select enable keeps contents when deselected
	always_ff @(posedge serialClk)
	begin
		if (!chipSelN)
		begin
			st_r <= st_nxt;
		end
	end

	assign frameOut = st_r;

endmodule : sdil_shift

// [design/sdil_top.sv]
// serial dac input logic: link capture, holding latch, decoder and two latch stages
module sdil_top #(
	parameter int RESOLUTION = 12 // converter resolution: 12, 10 or 8
) (
	input wire logic clk, // system clock, 250 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic serialClk, // serial clock pin, link clock domain
	input wire logic chipSelN, // chip select pin, active low
	input wire logic serialData, // serial data pin
	output logic [RESOLUTION-1:0] dacCode, // code applied to the converter
	output logic [RESOLUTION-1:0] inputCode, // code staged in the input latch
	output logic [sdil_pkg::CTRL_BITS-1:0] lastCommand, // last decoded control field
	output logic [15:0] frameCount, // number of accepted words
	output logic longFrame, // last accepted frame had extra clocks
	output logic frameActive, // chip select seen low, level
	output sdil_pkg::sdil_event_t events // one-cycle decoder pulses
);
	import sdil_pkg::*;

	// don't-care data bits below the resolution
	localparam int DROP_BITS = DATA_BITS - RESOLUTION;

	// complete state of the clk domain
	typedef struct packed {
		sdil_phase_t phase;
		sdil_word_t holdWord;
		logic [DATA_BITS-1:0] inputLatch;
		logic [DATA_BITS-1:0] dacLatch;
		logic [CTRL_BITS-1:0] lastCmd;
		logic [15:0] frames;
		logic longFlag;
		sdil_event_t ev;
	} sdil_state_t;

	sdil_state_t st_r;
	sdil_state_t st_nxt;
	sdil_frame_t linkFrame;
	logic csnLevel;

	// zero the data bits that this resolution treats as don't-care
	function automatic logic [DATA_BITS-1:0] usefulData(input logic [DATA_BITS-1:0] raw);
		logic [DATA_BITS-1:0] mask;
		mask = {DATA_BITS{1'b1}};
		mask = mask << DROP_BITS;
		return raw & mask;
	endfunction : usefulData

	// true when the control field asks for an input latch load
	function automatic logic wantsLoad(input logic [CTRL_BITS-1:0] cmd);
		return (cmd == CMD_LOAD) || (cmd == CMD_LOAD_UPDATE);
	endfunction : wantsLoad

	// true when the control field asks for a dac update
	function automatic logic wantsUpdate(input logic [CTRL_BITS-1:0] cmd);
		return (cmd == CMD_UPDATE) || (cmd == CMD_LOAD_UPDATE);
	endfunction : wantsUpdate

	// link side: shift register on the serial clock
	sdil_shift u_shift (
		.serialClk(serialClk),
		.chipSelN(chipSelN),
		.serialData(serialData),
		.frameOut(linkFrame)
	);

	// chip select brought into the clk domain
	sdil_sync #(
		.RESET_LEVEL(CSN_IDLE)
	) u_csn_sync (
		.clk(clk),
		.resetn(resetn),
		.pinIn(chipSelN),
		.levelOut(csnLevel)
	);

	// frame tracking, word capture and command decode
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ev = '0;
		case (st_r.phase)
			PH_IDLE:
			begin
				// wait for a frame to open
				if (!csnLevel)
				begin
					st_nxt.phase = PH_FRAME;
				end
			end
			PH_FRAME:
			begin
				// the link word is quiet once chip select is high again
				if (csnLevel)
				begin
					if (linkFrame.bitCount >= COUNT_FULL)
					begin
						st_nxt.holdWord = linkFrame.word;
						st_nxt.longFlag = (linkFrame.bitCount != COUNT_FULL);
						st_nxt.frames = st_r.frames + 16'h0001;
						st_nxt.phase = PH_DECODE;
					end
					else
					begin
						st_nxt.ev.shortPulse = 1'b1;
						st_nxt.phase = PH_IDLE;
					end
				end
			end
			PH_DECODE:
			begin
				// apply the held word to the two latch stages
				st_nxt.lastCmd = st_r.holdWord.controlCommandField;
				if (wantsLoad(st_r.holdWord.controlCommandField))
				begin
					st_nxt.inputLatch = usefulData(st_r.holdWord.dataField);
					st_nxt.ev.loadPulse = 1'b1;
				end
				if (st_r.holdWord.controlCommandField == CMD_UPDATE)
				begin
					st_nxt.dacLatch = st_r.inputLatch;
				end
				else if (wantsUpdate(st_r.holdWord.controlCommandField))
				begin
					st_nxt.dacLatch = usefulData(st_r.holdWord.dataField);
				end
				st_nxt.ev.updatePulse = wantsUpdate(st_r.holdWord.controlCommandField);
				st_nxt.ev.noopPulse = !wantsLoad(st_r.holdWord.controlCommandField)
					&& !wantsUpdate(st_r.holdWord.controlCommandField);
				st_nxt.phase = csnLevel ? PH_IDLE : PH_FRAME;
			end
			default:
			begin
				st_nxt.phase = PH_IDLE;
			end
		endcase
	end

	// register the state; reset clears every latch
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_r.phase <= PH_IDLE;
			st_r.holdWord <= '0;
			st_r.inputLatch <= LATCH_RESET;
			st_r.dacLatch <= LATCH_RESET;
			st_r.lastCmd <= CMD_RESET;
			st_r.frames <= 16'h0000;
			st_r.longFlag <= 1'b0;
			st_r.ev <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// outputs: latch codes as unsigned straight binary of the resolution
	assign dacCode = st_r.dacLatch[DATA_MSB -: RESOLUTION];
	assign inputCode = st_r.inputLatch[DATA_MSB -: RESOLUTION];
	assign lastCommand = st_r.lastCmd;
	assign frameCount = st_r.frames;
	assign longFrame = st_r.longFlag;
	assign frameActive = (st_r.phase == PH_FRAME);
	assign events = st_r.ev;

endmodule : sdil_top

// [test/sdil_top_properties.sv]
// port checker of the serial dac input logic
module sdil_properties #(
	parameter int RESOLUTION = 12 // converter resolution
) (
	input wire logic clk, // system clock
	input wire logic resetn, // reset, active low
	input wire logic serialClk, // serial clock
	input wire logic chipSelN, // chip select, active low
	input wire logic serialData, // serial data
	input wire logic [RESOLUTION-1:0] dacCode, // dac latch
	input wire logic [RESOLUTION-1:0] inputCode, // input latch
	input wire logic [sdil_pkg::CTRL_BITS-1:0] lastCommand, // last command
	input wire logic [15:0] frameCount, // accepted words
	input wire logic longFrame, // extra clocks seen
	input wire logic frameActive, // frame in progress
	input wire sdil_pkg::sdil_event_t events // decoder pulses
);
	timeunit 1ns;
	timeprecision 100ps;
	import sdil_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// any decoded word
	wire logic decoded = events.loadPulse | events.updatePulse | events.noopPulse;
	// latch stages move only on their commands
	a_dac_needs_update: assert property (!$stable(dacCode) |-> events.updatePulse)
		else $error("dac code changed without update");
	a_input_needs_load: assert property (!$stable(inputCode) |-> events.loadPulse)
		else $error("input code changed without load");
	a_update_copy: assert property (events.updatePulse && !events.loadPulse |->
		dacCode == $past(inputCode) && lastCommand == CMD_UPDATE)
		else $error("update did not copy input latch");
	a_both_same: assert property (events.loadPulse && events.updatePulse |->
		dacCode == inputCode && lastCommand == CMD_LOAD_UPDATE)
		else $error("load and update disagree");
	a_noop_keeps: assert property (events.noopPulse |-> lastCommand > CMD_LOAD_UPDATE
		&& $stable(dacCode) && $stable(inputCode))
		else $error("no-op changed a latch");
	a_short_drop: assert property (events.shortPulse |-> $stable(frameCount))
		else $error("short frame was counted");
	a_count_step: assert property (decoded |-> frameCount == $past(frameCount, 2) + 16'h1)
		else $error("frame count did not step");
	a_cs_first: assert property (decoded || events.shortPulse |-> $past(chipSelN, 3))
		else $error("decode before chip select rose");
	a_active_low: assert property ($rose(frameActive) |-> !$past(chipSelN, 4))
		else $error("frame opened without chip select low");
endmodule : sdil_properties

bind sdil_top sdil_properties #(.RESOLUTION(RESOLUTION)) i_props (.clk(clk), .resetn(resetn),
	.serialClk(serialClk), .chipSelN(chipSelN), .serialData(serialData), .dacCode(dacCode),
	.inputCode(inputCode), .lastCommand(lastCommand), .frameCount(frameCount),
	.longFrame(longFrame), .frameActive(frameActive), .events(events));

// [test/sdil_host.sv]
// host model driving the serial link pins
module sdil_host (
	output logic serialClk, // serial clock, low when idle, four stray pulses after each frame
	output logic chipSelN, // chip select, active low
	output logic serialData // serial data
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle pin levels
	initial
	begin
		serialClk = 1'b0;
		chipSelN = 1'b1;
		serialData = 1'b0;
	end
	// one frame of n clocks at 6 ns, last sixteen carry w, then stray deselected clocks
	task automatic sendWord(input logic [15:0] w, input int n);
		logic b;
		b = 1'b0;
		serialClk = 1'b0;
		chipSelN = 1'b0;
		#15.5;
		for (int k = 0; k < n; k++)
		begin
			b = (n - k <= 16) ? w[n-1-k] : 1'b1;
			serialData = b;
			#3 serialClk = 1'b1;
			#3 serialClk = 1'b0;
		end
		#3 chipSelN = 1'b1;
		serialData = ~b; // released line shows no stale bit
		// clocks while deselected must not disturb the word awaiting capture
		repeat (4)
		begin
			#3 serialClk = 1'b1;
			#3 serialClk = 1'b0;
		end
		#16;
	endtask : sendWord
endmodule : sdil_host

// [test/sdil_top_tb.sv]
// testbench of the serial dac input logic
module sdil_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sdil_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic serialClk, chipSelN, serialData, longFrame;
	logic [11:0] dacCode, inputCode;
	logic [7:0] dac8;
	logic [9:0] dac10;
	logic [3:0] lastCommand;
	logic [15:0] frameCount;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// 250 MHz clock
	initial
	begin
		forever #2 clk = ~clk;
	end
	sdil_host i_host (.serialClk(serialClk), .chipSelN(chipSelN), .serialData(serialData));
	sdil_top i_dut (.clk(clk), .resetn(resetn), .serialClk(serialClk), .chipSelN(chipSelN),
		.serialData(serialData), .dacCode(dacCode), .inputCode(inputCode),
		.lastCommand(lastCommand), .frameCount(frameCount), .longFrame(longFrame),
		.frameActive(), .events());
	sdil_top #(.RESOLUTION(8)) i_dut8 (.clk(clk), .resetn(resetn), .serialClk(serialClk),
		.chipSelN(chipSelN), .serialData(serialData), .dacCode(dac8), .inputCode(),
		.lastCommand(), .frameCount(), .longFrame(), .frameActive(), .events());
	sdil_top #(.RESOLUTION(10)) i_dut10 (.clk(clk), .resetn(resetn), .serialClk(serialClk),
		.chipSelN(chipSelN), .serialData(serialData), .dacCode(dac10), .inputCode(),
		.lastCommand(), .frameCount(), .longFrame(), .frameActive(), .events());
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// counts and verdict
	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// one frame, then the fixed decode latency
	task automatic frame(input logic [15:0] w, input int n);
		i_host.sendWord(w, n);
		repeat (3) @(negedge clk);
	endtask : frame
	// latches and status right after reset
	task automatic testReset;
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		check(16'(dacCode), 16'h0000);
		check(16'(inputCode), 16'h0000);
		check(16'(lastCommand), 16'h0000);
		check(frameCount, 16'h0000);
	endtask : testReset
	// load, update-only and load-and-update, the last also checked at resolutions 8 and 10
	task automatic testLoadUpdate;
		frame({CMD_LOAD, 12'h5A3}, 16);
		check(16'(inputCode), 16'h05A3);
		check(16'(dacCode), 16'h0000);
		frame({CMD_UPDATE, 12'hFFF}, 16);
		check(16'(dacCode), 16'h05A3);
		check(16'(inputCode), 16'h05A3);
		frame({CMD_LOAD_UPDATE, 12'hABC}, 16);
		check(16'(dacCode), 16'h0ABC);
		check(16'(dac8), 16'h00AB);
		check(16'(dac10), 16'h02AF);
	endtask : testLoadUpdate
	// every no-op code leaves both latches alone
	task automatic testNoop;
		for (int c = 3; c < 16; c++)
		begin
			frame({4'(c), 12'h123}, 16);
			check(16'(lastCommand), 16'(c));
			check(16'(inputCode), 16'h0ABC);
			check(16'(dacCode), 16'h0ABC);
		end
	endtask : testNoop
	// a cut frame is dropped, a long one keeps its last sixteen bits
	task automatic testShortLong;
		frame({CMD_LOAD, 12'h111}, 15);
		check(16'(inputCode), 16'h0ABC);
		check(frameCount, 16'h0010);
		frame({CMD_LOAD_UPDATE, 12'h456}, 20);
		check(16'(dacCode), 16'h0456);
		check(16'(longFrame), 16'h0001);
		check(frameCount, 16'h0011);
	endtask : testShortLong
	// reset, then the scenarios
	initial
	begin
		testReset();
		testLoadUpdate();
		testNoop();
		testShortLong();
		summarize();
	end
	// cycle ceiling against a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fail_count++;
			summarize();
		end
	end
endmodule : sdil_top_tb
